/* rtl/aji_pkg.sv */
// Shared constants and types for the absolute jump / increment execution block.
// Assumes a single 100 MHz core clock and an APB register port with 32-bit data.
package aji_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int PC_W    = 21;
    localparam int FADDR_W = 12;
    localparam int DATA_W  = 8;
    localparam int INSTR_W = 16;
    localparam int APB_AW  = 8;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h04;
    localparam logic [7:0] WREG_OFS    = 8'h08;
    localparam logic [7:0] BANKSEL_OFS = 8'h0c;
    localparam logic [7:0] INDEX_OFS   = 8'h10;
    localparam logic [7:0] PC_OFS      = 8'h14;
    localparam logic [7:0] FADDR_OFS   = 8'h18;
    localparam logic [7:0] FDATA_OFS   = 8'h1c;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;
    localparam int FLAGS_W      = 5;
    localparam int BANK_W       = 4;

    localparam logic [1:0]         CTRL_RST  = 2'h0;
    localparam logic [DATA_W-1:0]  WREG_RST  = 8'h00;
    localparam logic [BANK_W-1:0]  BANK_RST  = 4'h0;
    localparam logic [FADDR_W-1:0] INDEX_RST = 12'h000;
    localparam logic [PC_W-1:0]    PC_RST    = 21'h000000;
    localparam logic [PC_W-1:0]    PC_STEP   = 21'h000002;

    // ----------------------------------------
    // Opcodes and addressing constants
    // ----------------------------------------
    localparam logic [5:0]        OPC_INC_FILE  = 6'h0a;
    localparam logic [7:0]        OPC_JUMP      = 8'hef;
    localparam logic [DATA_W-1:0] ACCESS_SPLIT  = 8'h80;
    localparam logic [DATA_W-1:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic n;
        logic signed_wrap_flag;
        logic z;
        logic nibble_spill_flag;
        logic c;
    } aji_flags_t;

    typedef struct packed {
        logic               we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  wdata;
    } aji_mem_req_t;

    typedef enum logic [1:0] {
        Q1,
        Q2,
        Q3,
        Q4
    } aji_q_t;

endpackage

/* rtl/aji_file_ram.sv */
// File register memory of the execution block.
// Assumes one request per clock; read data appear one edge after the request.
`timescale 1ns/1ps
module aji_file_ram #(
    parameter int DEPTH_W = 12,
    parameter int WIDTH   = 8
) (
    input  wire logic                   clk_i,
    input  wire logic                   arst_n_i,
    input  wire aji_pkg::aji_mem_req_t  req_i,
    output logic [WIDTH-1:0]            rdata_o
);

    logic [WIDTH-1:0] mem_ff [0:(1<<DEPTH_W)-1];
    logic [WIDTH-1:0] rdata_ff;

    // ----------------------------------------
    // Storage, no reset on the array
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (req_i.we)
        begin
            mem_ff[req_i.addr[DEPTH_W-1:0]] <= req_i.wdata[WIDTH-1:0];
        end
    end

    // ----------------------------------------
    // Registered read port
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= mem_ff[req_i.addr[DEPTH_W-1:0]];
        end
    end

    assign rdata_o = rdata_ff;

endmodule

/* rtl/aji_core.sv */
// Core slice executing the absolute jump and the file increment instructions.
// Assumes program memory on the same clock presents instruction words with a valid/ready handshake.
// What this block does
// - Jump loads its 20-bit literal into program counter bits 20..1.
// - Jump takes two program words and two instruction cycles, plus any cycles stalled in Q3 waiting for the second word.
// - Increment adds one to the file register and updates carry, nibble, sign, wrap, zero flags.
// - Destination bit 0 writes the accumulator, 1 writes back the file register.
// - Access bit 0 selects the access bank, 1 uses the bank select register.
// - Extended set, access bit 0, address up to 5Fh: indexed literal offset.
// - Increment opcode is 001010, then destination, access and 8-bit address.
// - Jump is an unconditional branch that changes no status flags.
`timescale 1ns/1ps
module aji_core #(
    parameter int FADDR_W = aji_pkg::FADDR_W
) (
    input  wire logic                        clk_i,
    input  wire logic                        arst_n_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [aji_pkg::APB_AW-1:0]  paddr_i,
    input  wire logic [31:0]                 pwdata_i,
    output logic [31:0]                      prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    output logic [aji_pkg::PC_W-1:0]         pc_o,
    input  wire logic [aji_pkg::INSTR_W-1:0] instr_i,
    input  wire logic                        instr_valid_i,
    output logic                             instr_ready_o
);

    logic [1:0]                    ctrl_ff;
    aji_pkg::aji_flags_t           flags_ff;
    logic [aji_pkg::DATA_W-1:0]    wreg_ff;
    logic [aji_pkg::BANK_W-1:0]    bank_select_register_ff;
    logic [FADDR_W-1:0]            index_ff;
    logic [aji_pkg::PC_W-1:0]      pc_ff;
    logic [FADDR_W-1:0]            faddr_ff;
    logic [31:0]                   prdata_ff;
    logic                          pslverr_ff;
    aji_pkg::aji_q_t               q_ff;
    logic [aji_pkg::INSTR_W-1:0]   instr_ff;
    logic                          flush_ff;
    logic [7:0]                    klo_ff;
    logic [11:0]                   khi_ff;
    logic [aji_pkg::DATA_W-1:0]    res_ff;
    aji_pkg::aji_flags_t           res_flags_ff;
    logic [aji_pkg::DATA_W-1:0]    rdata;
    aji_pkg::aji_mem_req_t         mem_req;
    logic                          run;
    logic                          ext_en;
    logic                          exec_jump;
    logic                          exec_inc;
    logic                          dest_file;
    logic                          access_bsr;
    logic [7:0]                    file_addr;
    logic [FADDR_W-1:0]            eff_addr;
    logic                          apb_setup;
    logic                          apb_write;
    logic                          mapped;

    assign run        = ctrl_ff[aji_pkg::CTRL_RUN_BIT];
    assign ext_en     = ctrl_ff[aji_pkg::CTRL_EXT_BIT];
    assign exec_jump  = (instr_ff[15:8] == aji_pkg::OPC_JUMP) && !flush_ff;
    assign exec_inc   = (instr_ff[15:10] == aji_pkg::OPC_INC_FILE) && !flush_ff;
    assign dest_file  = instr_ff[9];
    assign access_bsr = instr_ff[8];
    assign file_addr  = instr_ff[7:0];

    // ----------------------------------------
    // Operand address
    // ----------------------------------------
    always_comb
    begin
        if (access_bsr)
        begin
            eff_addr = FADDR_W'({bank_select_register_ff, file_addr});
        end
        else if (ext_en && (file_addr <= aji_pkg::INDEXED_LIMIT))
        begin
            // Index base plus literal offset, wrapping inside the file space
            eff_addr = index_ff + FADDR_W'(file_addr);
        end
        else if (file_addr < aji_pkg::ACCESS_SPLIT)
        begin
            eff_addr = FADDR_W'({aji_pkg::ACCESS_LO_BANK, file_addr});
        end
        else
        begin
            eff_addr = FADDR_W'({aji_pkg::ACCESS_HI_BANK, file_addr});
        end
    end

    // ----------------------------------------
    // Memory port: core while running, software while halted
    // ----------------------------------------
    always_comb
    begin
        mem_req.we    = 1'b0;
        mem_req.addr  = eff_addr;
        mem_req.wdata = res_ff;
        if (!run)
        begin
            mem_req.addr  = faddr_ff;
            mem_req.wdata = pwdata_i[aji_pkg::DATA_W-1:0];
            mem_req.we    = apb_write && (paddr_i == aji_pkg::FDATA_OFS);
        end
        else if (q_ff == aji_pkg::Q4 && exec_inc && dest_file)
        begin
            mem_req.we = 1'b1;
        end
    end

    aji_file_ram #(
        .DEPTH_W (FADDR_W),
        .WIDTH   (aji_pkg::DATA_W)
    ) u_ram (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .req_i    (mem_req),
        .rdata_o  (rdata)
    );

    // ----------------------------------------
    // Quarter-cycle sequencer
    // ----------------------------------------
    // A halted core fetches nothing new: it steps the current instruction and any pending flush through Q4, file port given to software, then waits in Q1.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            q_ff     <= aji_pkg::Q1;
            instr_ff <= '0;
            flush_ff <= 1'b0;
            klo_ff   <= '0;
            khi_ff   <= '0;
        end
        else
        begin
            unique case (q_ff)
                aji_pkg::Q1:
                begin
                    if (flush_ff)
                    begin
                        q_ff <= aji_pkg::Q2;
                    end
                    else if (run && instr_valid_i)
                    begin
                        instr_ff <= instr_i;
                        q_ff     <= aji_pkg::Q2;
                    end
                end
                aji_pkg::Q2:
                begin
                    klo_ff <= instr_ff[7:0];
                    q_ff   <= aji_pkg::Q3;
                end
                aji_pkg::Q3:
                begin
                    // Reloaded every stall cycle; the word standing at the taking edge is kept
                    khi_ff <= instr_i[11:0];
                    if (!exec_jump || instr_valid_i)
                    begin
                        q_ff <= aji_pkg::Q4;
                    end
                end
                aji_pkg::Q4:
                begin
                    flush_ff <= exec_jump;
                    q_ff     <= aji_pkg::Q1;
                end
            endcase
        end
    end

    assign instr_ready_o = (q_ff == aji_pkg::Q1 && !flush_ff && run) ||
                           (q_ff == aji_pkg::Q3 && exec_jump);

    // ----------------------------------------
    // Increment datapath
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            res_ff       <= '0;
            res_flags_ff <= '0;
        end
        else if (q_ff == aji_pkg::Q3 && exec_inc)
        begin
            res_ff                         <= rdata + 8'h01;
            res_flags_ff.c                 <= (rdata == 8'hff);
            res_flags_ff.nibble_spill_flag <= (rdata[3:0] == 4'hf);
            res_flags_ff.signed_wrap_flag  <= (rdata == 8'h7f);
            res_flags_ff.z                 <= (rdata == 8'hff);
            res_flags_ff.n                 <= (rdata + 8'h01) >= 8'h80;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Zero wait states: read data and error are prepared in the setup cycle.
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pwrite_i;
    assign mapped    = (paddr_i[1:0] == 2'b00) && (paddr_i <= aji_pkg::FDATA_OFS);
    assign pready_o  = 1'b1;
    assign prdata_o  = prdata_ff;
    assign pslverr_o = pslverr_ff;
    assign pc_o      = (q_ff == aji_pkg::Q3 && exec_jump) ? pc_ff + aji_pkg::PC_STEP : pc_ff;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end
        else if (apb_setup)
        begin
            // Memory data may only be loaded while halted
            pslverr_ff <= !mapped || (pwrite_i && run && paddr_i == aji_pkg::FDATA_OFS);
            unique case (paddr_i)
                aji_pkg::CTRL_OFS:    prdata_ff <= 32'(ctrl_ff);
                aji_pkg::STATUS_OFS:  prdata_ff <= 32'(flags_ff);
                aji_pkg::WREG_OFS:    prdata_ff <= 32'(wreg_ff);
                aji_pkg::BANKSEL_OFS: prdata_ff <= 32'(bank_select_register_ff);
                aji_pkg::INDEX_OFS:   prdata_ff <= 32'(index_ff);
                aji_pkg::PC_OFS:      prdata_ff <= 32'(pc_ff);
                aji_pkg::FADDR_OFS:   prdata_ff <= 32'(faddr_ff);
                default:              prdata_ff <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_ff                 <= aji_pkg::CTRL_RST;
            bank_select_register_ff <= aji_pkg::BANK_RST;
            index_ff                <= aji_pkg::INDEX_RST;
            faddr_ff                <= '0;
        end
        else if (apb_write)
        begin
            unique case (paddr_i)
                aji_pkg::CTRL_OFS:    ctrl_ff                 <= pwdata_i[1:0];
                aji_pkg::BANKSEL_OFS: bank_select_register_ff <= pwdata_i[aji_pkg::BANK_W-1:0];
                aji_pkg::INDEX_OFS:   index_ff                <= pwdata_i[FADDR_W-1:0];
                aji_pkg::FADDR_OFS:   faddr_ff                <= pwdata_i[FADDR_W-1:0];
                default:              ;
            endcase
        end
    end

    // ----------------------------------------
    // Architectural state: a software write is dropped in every Q4 cycle, with or without a hardware update
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flags_ff <= '0;
            wreg_ff  <= aji_pkg::WREG_RST;
            pc_ff    <= aji_pkg::PC_RST;
        end
        else if (q_ff == aji_pkg::Q4)
        begin
            if (exec_jump)
            begin
                pc_ff <= {khi_ff, klo_ff, 1'b0};
            end
            else if (!flush_ff)
            begin
                pc_ff <= pc_ff + aji_pkg::PC_STEP;
            end
            if (exec_inc)
            begin
                flags_ff <= res_flags_ff;
                if (!dest_file)
                begin
                    wreg_ff <= res_ff;
                end
            end
        end
        else if (apb_write)
        begin
            unique case (paddr_i)
                aji_pkg::STATUS_OFS: flags_ff <= pwdata_i[aji_pkg::FLAGS_W-1:0];
                aji_pkg::WREG_OFS:   wreg_ff  <= pwdata_i[aji_pkg::DATA_W-1:0];
                aji_pkg::PC_OFS:     pc_ff    <= {pwdata_i[aji_pkg::PC_W-1:1], 1'b0};
                default:             ;
            endcase
        end
    end

endmodule

/* tb/aji_core_sva.sv */
// Port checker for the jump / increment execution slice.
// Assumes the fetch handshake and zero-wait APB timing of the execution slice.
`timescale 1ns/1ps
module aji_core_sva #(
    parameter int FADDR_W = 12
) (
    input  wire logic                        clk_i,
    input  wire logic                        arst_n_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [aji_pkg::APB_AW-1:0]  paddr_i,
    input  wire logic [31:0]                 prdata_o,
    input  wire logic                        pready_o,
    input  wire logic                        pslverr_o,
    input  wire logic [aji_pkg::PC_W-1:0]    pc_o,
    input  wire logic [aji_pkg::INSTR_W-1:0] instr_i,
    input  wire logic                        instr_valid_i,
    input  wire logic                        instr_ready_o
);
    // ----
    // Word tracking
    // ----
    logic       take;
    logic       first;
    logic       jmp2_ff;
    logic [7:0] klo_ff;

    assign take  = instr_valid_i && instr_ready_o;
    assign first = take && !jmp2_ff;

    // Second jump word must not be decoded as a new instruction
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            jmp2_ff <= 1'b0;
        else if (take)
            jmp2_ff <= first && instr_i[15:8] == aji_pkg::OPC_JUMP;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            klo_ff <= 8'h00;
        else if (first)
            klo_ff <= instr_i[7:0];
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    apb_ready_a: assert property (psel_i && penable_i |-> pready_o ##1 $stable(prdata_o) && $stable(pslverr_o))
        else $error("access phase without ready or answer not held");
    bad_read_a: assert property (psel_i && !penable_i && !pwrite_i
        && (paddr_i > aji_pkg::FDATA_OFS || paddr_i[1:0] != 2'h0)
        |=> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped read not refused");
    pc_even_a: assert property (pc_o[0] == 1'b0)
        else $error("odd fetch address");
    jump_second_a: assert property (first && instr_i[15:8] == aji_pkg::OPC_JUMP
        |-> ##2 instr_ready_o && pc_o == $past(pc_o, 2) + 21'h2)
        else $error("second jump word not fetched at pc plus two");
    jump_target_a: assert property (take && jmp2_ff
        |-> ##2 pc_o == {$past(instr_i[11:0], 2), klo_ff, 1'b0})
        else $error("jump target wrong");
    jump_flush_a: assert property (take && jmp2_ff |-> ##1 !instr_ready_o [*5])
        else $error("fetch during jump flush cycle");
    inc_single_a: assert property (first && instr_i[15:10] == aji_pkg::OPC_INC_FILE
        |=> !instr_ready_o [*3])
        else $error("increment fetch inside its own cycle");
    step_pc_a: assert property (first && instr_i[15:8] != aji_pkg::OPC_JUMP
        |-> ##4 pc_o == $past(pc_o, 4) + 21'h2)
        else $error("single word instruction did not step pc");
endmodule

bind aji_core aji_core_sva #(.FADDR_W(FADDR_W)) i_aji_core_sva (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pc_o(pc_o), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o)
);

/* tb/testbench.sv */
// Self-checking bench for the jump / increment execution slice.
// Drives APB and the fetch port itself; file memory is loaded while halted.
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [20:0] pc_o;
    logic [15:0] instr_i = 16'h0000;
    logic        instr_valid_i = 1'b0;
    logic        instr_ready_o;
    int          mismatches = 0;
    int          checked = 0;
    int          cyc = 0;
    int          take_cyc;
    logic [31:0] rd;
    logic        er;
    logic [20:0] pc_exp = 21'h0;

    aji_core i_aji_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .pc_o(pc_o), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o));

    always #5 clk_i = ~clk_i;

    // ----
    // Helpers
    // ----
    task automatic print_verdict();
        $display("checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Counted on the falling edge so a take time read at a rising edge is settled
    always @(negedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, ex, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1)
            @(posedge clk_i);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Leaves valid high so a following word can be offered at the take edge
    task automatic feed(input logic [15:0] w);
        instr_i <= w;
        instr_valid_i <= 1'b1;
        @(negedge clk_i);
        while (instr_ready_o !== 1'b1)
            @(negedge clk_i);
        @(posedge clk_i);
        take_cyc = cyc;
    endtask

    function automatic logic [11:0] ea(input logic [7:0] f, input logic a, ext, input logic [3:0] b,
                                       input logic [11:0] ix);
        if (a)
            return {b, f};
        if (ext && f <= aji_pkg::INDEXED_LIMIT)
            return ix + {4'h0, f};
        if (f < aji_pkg::ACCESS_SPLIT)
            return {aji_pkg::ACCESS_LO_BANK, f};
        return {aji_pkg::ACCESS_HI_BANK, f};
    endfunction

    // Flags after incrementing x, packed sign, signed wrap, zero, nibble spill, carry
    function automatic logic [4:0] flg(input logic [7:0] x);
        logic [7:0] r;
        r = x + 8'h01;
        return {r[7], x == 8'h7f, r == 8'h00, x[3:0] == 4'hf, x == 8'hff};
    endfunction

    // ----
    // Tests
    // ----
    // Second increment always targets the accumulator, so a write-back shows as plus two
    task automatic inc_test(input logic [7:0] f, v, input logic d, a, ext);
        logic [3:0]  b;
        logic [11:0] ix;
        int          t0;
        b = 4'($urandom);
        ix = 12'($urandom);
        apb(1'b1, aji_pkg::BANKSEL_OFS, {28'h0, b});
        apb(1'b1, aji_pkg::INDEX_OFS, {20'h0, ix});
        apb(1'b1, aji_pkg::FADDR_OFS, {20'h0, ea(f, a, ext, b, ix)});
        apb(1'b1, aji_pkg::FDATA_OFS, {24'h0, v});
        apb(1'b1, aji_pkg::CTRL_OFS, {30'h0, ext, 1'b1});
        feed({aji_pkg::OPC_INC_FILE, d, a, f});
        t0 = take_cyc;
        feed({aji_pkg::OPC_INC_FILE, 1'b0, a, f});
        chk("increment cycles", 32'd4, 32'(take_cyc - t0));
        instr_valid_i <= 1'b0;
        apb(1'b1, aji_pkg::CTRL_OFS, 32'h0);
        pc_exp = pc_exp + 21'h4;
        apb(1'b0, aji_pkg::WREG_OFS, 32'h0);
        chk("wreg", {24'h0, v + (d ? 8'h02 : 8'h01)}, rd);
        apb(1'b0, aji_pkg::STATUS_OFS, 32'h0);
        chk("status", {27'h0, flg(v + {7'h0, d})}, rd);
        apb(1'b0, aji_pkg::PC_OFS, 32'h0);
        chk("pc", {11'h0, pc_exp}, rd);
        $display("increment f=%h v=%h d=%b a=%b ext=%b done", f, v, d, a, ext);
    endtask

    task automatic jump_test(input logic [19:0] k);
        logic [31:0] st;
        int          t0;
        st = {27'h0, 5'($urandom)};
        apb(1'b1, aji_pkg::STATUS_OFS, st);
        apb(1'b1, aji_pkg::CTRL_OFS, 32'h1);
        feed({aji_pkg::OPC_JUMP, k[7:0]});
        t0 = take_cyc;
        feed({4'ha, k[19:8]});
        chk("second word", 32'd2, 32'(take_cyc - t0));
        feed(16'h0000);
        chk("jump cycles", 32'd8, 32'(take_cyc - t0));
        instr_valid_i <= 1'b0;
        apb(1'b1, aji_pkg::CTRL_OFS, 32'h0);
        pc_exp = {k, 1'b0} + 21'h2;
        apb(1'b0, aji_pkg::PC_OFS, 32'h0);
        chk("jump pc", {11'h0, pc_exp}, rd);
        chk("fetch address", {11'h0, pc_exp}, {11'h0, pc_o});
        apb(1'b0, aji_pkg::STATUS_OFS, 32'h0);
        chk("jump status", st, rd);
        $display("jump k=%h done", k);
    endtask

    initial
    begin
        rd = $urandom(32'h3cea);
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'b0, 8'h06, 32'h0);
        chk("unaligned error", 32'h1, {31'h0, er});
        apb(1'b1, aji_pkg::CTRL_OFS, 32'h1);
        apb(1'b1, aji_pkg::FDATA_OFS, 32'h55);
        chk("fdata while running", 32'h1, {31'h0, er});
        apb(1'b1, aji_pkg::CTRL_OFS, 32'h0);
        $display("register test done");
        inc_test(8'h10, 8'hff, 1'b0, 1'b0, 1'b0);
        inc_test(8'h20, 8'h7f, 1'b0, 1'b1, 1'b0);
        inc_test(8'h5f, 8'h0f, 1'b1, 1'b0, 1'b1);
        inc_test(8'h60, 8'h8e, 1'b1, 1'b0, 1'b1);
        inc_test(8'h80, 8'h00, 1'b1, 1'b0, 1'b1);
        jump_test(20'hfffff);
        jump_test(20'h00000);
        for (int i = 0; i < 16; i++)
        begin
            inc_test(8'($urandom), 8'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
            if (i % 4 == 0)
                jump_test(20'($urandom));
        end
        print_verdict();
    end
endmodule
